// >>> sim/sae_codec_model.sv
module sae_codec_model (
    output logic             link_clk,
    output logic             sdi,
    output logic             fs,
    input  wire logic        ws,
    input  wire logic        sdo,
    input  wire logic        fill,
    input  wire logic        fault,
    input  wire logic [15:0] word,
    output int               n_word,
    output int               n_other,
    output int               n_slot
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] shift;
    logic        ws_q = 1'b0;
    int          bits = 17;
    assign sdi = fill;
    // free-running codec clock, phase unrelated to the core clock
    initial begin
        link_clk = 1'b0;
        #7;
        forever begin
            link_clk = ~link_clk;
            #40;
        end
    end
    // a sync edge five bits into a slot is always mid-frame
    always @(posedge link_clk) fs <= fault && bits == 5;
    // capture from the word-select change: slot and word are both 16 bits
    always @(negedge link_clk) begin
        if (ws !== ws_q) begin
            shift = {15'h0, sdo};
            bits = 1;
        end else if (bits < 16) begin
            shift = {shift[14:0], sdo};
            bits++;
        end
        ws_q = ws;
        if (bits == 16) begin
            n_slot++;
            n_word += int'(shift === word);
            n_other += int'(shift !== word && shift !== 16'h0);
            bits = 17;
        end
    end
endmodule

// >>> sim/sae_top_monitor.sv
`include "sae_consts.svh"
module sae_top_monitor
    import sae_pkg::*;
(
    input wire logic                   CORE_CLK,
    input wire logic                   RST_B,
    input wire logic [`SAE_ADDR_W-1:0] ADDR,
    input wire logic [31:0]            WDATA,
    input wire logic                   WR,
    input wire logic                   RD,
    input wire logic [31:0]            RDATA,
    input wire logic                   LINK_CLK,
    input wire logic                   LINK_WS,
    input wire logic                   LINK_SDO,
    input wire logic                   LINK_SDI,
    input wire logic                   LINK_FS,
    input wire logic                   ERR_EVENT
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic        on_ff;
    logic [3:0]  quiet_ff;
    logic [1:0]  aud_ff;
    logic        wr_ctrl;
    logic        mapped;
    assign wr_ctrl = WR && ADDR == `SAE_OFF_CTRL2;
    assign mapped = ADDR inside {`SAE_OFF_CTRL2, `SAE_OFF_CTRL1, `SAE_OFF_STATUS,
                                 `SAE_OFF_TXDATA, `SAE_OFF_RXDATA};
    // codec fields stay frozen while the port runs
    always_comb begin
        nxt_ctrl = WDATA & `SAE_CTRL2_MASK;
        if (on_ff) begin
            nxt_ctrl = (ctrl_ff & 32'h0000_008b) | (WDATA & 32'h0000_9f00);
        end
    end
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_ff <= `SAE_CTRL2_RESET;
            on_ff <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_ff <= nxt_ctrl;
        end else if (WR && ADDR == `SAE_OFF_CTRL1) begin
            on_ff <= WDATA[0];
        end
    end
    // events still in the sync pipe may predate a control change
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            quiet_ff <= 4'h0;
        end else if (wr_ctrl) begin
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hf) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end
    always_ff @(posedge LINK_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aud_ff <= 2'h0;
        end else begin
            aud_ff <= {aud_ff[0], ctrl_ff[7]};
        end
    end
    chk_ctrl_shadow: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $past(RD && ADDR == `SAE_OFF_CTRL2) |-> RDATA == $past(ctrl_ff))
        else $error("control two readback differs from shadow");
    chk_ctrl_holes: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $past(RD && ADDR == `SAE_OFF_CTRL2) |-> (RDATA & ~`SAE_CTRL2_MASK) == 32'h0)
        else $error("unimplemented control bits read nonzero");
    chk_rx_sign: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $past(RD && ADDR == `SAE_OFF_RXDATA) |-> RDATA[31:16] == {16{ctrl_ff[15] & RDATA[15]}})
        else $error("receive word extension wrong");
    chk_err_gated: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        ERR_EVENT && quiet_ff == 4'hf |-> ctrl_ff[12:10] != 3'b000)
        else $error("error event with all event enables clear");
    chk_err_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $rose(ERR_EVENT) |=> !ERR_EVENT)
        else $error("error event longer than one cycle");
    chk_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read answer cycle");
    chk_unmapped_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $past(RD && !mapped) |-> RDATA == 32'h0)
        else $error("unmapped read nonzero");
    chk_ws_quiet: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
        !aud_ff[1] [*6] |-> !LINK_WS)
        else $error("word select active with codec protocol off");
endmodule
bind sae_top sae_top_monitor mon (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LINK_CLK(LINK_CLK), .LINK_WS(LINK_WS), .LINK_SDO(LINK_SDO),
    .LINK_SDI(LINK_SDI), .LINK_FS(LINK_FS), .ERR_EVENT(ERR_EVENT)
);

// >>> sim/test_spi_audio_error_control.sv
`include "sae_consts.svh"
module test_spi_audio_error_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] TX_WORD = 16'h5a3c;
    logic                   core_clk;
    logic                   rst_b;
    logic [`SAE_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
    logic [31:0]            rdata;
    logic                   link_clk;
    logic                   link_ws;
    logic                   link_sdo;
    logic                   link_sdi;
    logic                   link_fs;
    logic                   err_event;
    logic                   fill;
    logic                   fault;
    logic                   pend = 1'b0;
    logic [31:0]            v;
    logic [31:0]            exp_m;
    logic [31:0]            msk_m;
    logic [31:0]            exp_q[$];
    logic [31:0]            msk_q[$];
    int                     n_fail = 0;
    int                     check_count = 0;
    int                     n_err = 0;
    int                     seed = 78;
    int                     n_word, n_other, n_slot, w0, o0, s0, e0;
    sae_top dut (.CORE_CLK(core_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .LINK_CLK(link_clk), .LINK_WS(link_ws), .LINK_SDO(link_sdo),
        .LINK_SDI(link_sdi), .LINK_FS(link_fs), .ERR_EVENT(err_event));
    sae_codec_model codec (.link_clk(link_clk), .sdi(link_sdi), .fs(link_fs), .ws(link_ws),
        .sdo(link_sdo), .fill(fill), .fault(fault), .word(TX_WORD), .n_word(n_word),
        .n_other(n_other), .n_slot(n_slot));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask
    // a zero mask marks a polling read that is not compared
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        v = rdata;
        @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (pend && msk_q.size() > 0) begin
            exp_m = exp_q.pop_front();
            msk_m = msk_q.pop_front();
            if (msk_m != 32'h0) begin
                check("read data", rdata & msk_m, exp_m);
            end
        end
        pend <= rd;
    end
    always @(posedge core_clk) n_err += int'(err_event === 1'b1);
    // stopping the port first lets a stale slot finish before the snapshot
    task automatic run(input logic [31:0] c, input int n);
        wr_reg(`SAE_OFF_CTRL1, 32'h0);
        repeat (300) @(posedge core_clk);
        wr_reg(`SAE_OFF_STATUS, 32'h7);
        repeat (4) rdx(`SAE_OFF_RXDATA, 32'h0, 32'h0);
        w0 = n_word;
        o0 = n_other;
        s0 = n_slot;
        e0 = n_err;
        wr_reg(`SAE_OFF_CTRL2, c);
        wr_reg(`SAE_OFF_TXDATA, {16'h0, TX_WORD});
        wr_reg(`SAE_OFF_CTRL1, 32'h1);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end
    initial begin
        rst_b = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        fill = 1'b0;
        fault = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rdx(`SAE_OFF_CTRL2, `SAE_CTRL2_RESET, '1);
        wr_reg(`SAE_OFF_CTRL2, 32'hffff_ffff);
        rdx(`SAE_OFF_CTRL2, `SAE_CTRL2_MASK, '1);
        rdx(8'h40, 32'h0, '1);
        for (int s = 0; s < 4; s++) begin
            wr_reg(`SAE_OFF_CTRL2, 32'h80 | 32'(s));
            rdx(`SAE_OFF_CTRL2, 32'h80 | 32'(s), '1);
        end
        wr_reg(`SAE_OFF_CTRL1, 32'h1);
        repeat (4) begin
            v = $random(seed);
            wr_reg(`SAE_OFF_CTRL2, v);
            rdx(`SAE_OFF_CTRL2, (v & 32'h9f00) | 32'h83, '1);
        end
        $display("register test done");
        run(32'h0000_030b, 300);
        check("idle slots", 32'(n_slot - s0), 32'h0);
        $display("codec off test done");
        run(32'h0000_0389, 1200);
        check("mono copies", 32'(n_word - w0), 32'h2);
        check("fill slots", 32'(n_other - o0), 32'h0);
        check("slots seen", 32'(n_slot - s0 > 4), 32'h1);
        check("quiet events", 32'(n_err - e0), 32'h0);
        rdx(`SAE_OFF_STATUS, 32'h0, 32'h8);
        $display("mono underrun test done");
        run(32'h0000_0681, 600);
        rdx(`SAE_OFF_STATUS, 32'h8, 32'h8);
        check("underrun events", 32'(n_err - e0 > 0), 32'h1);
        $display("underrun halt test done");
        fill <= 1'b1;
        run(32'h0000_8b81, 600);
        fill <= 1'b0;
        repeat (300) @(posedge core_clk);
        rdx(`SAE_OFF_STATUS, 32'h1, 32'h9);
        rdx(`SAE_OFF_RXDATA, 32'hffff_ffff, '1);
        check("overflow events", 32'(n_err - e0 > 0), 32'h1);
        fill <= 1'b1;
        run(32'h0000_0b81, 600);
        rdx(`SAE_OFF_RXDATA, 32'h0000_ffff, '1);
        $display("overflow tolerate test done");
        run(32'h0000_0181, 600);
        rdx(`SAE_OFF_STATUS, 32'h8, 32'h8);
        check("masked overflow", 32'(n_err - e0), 32'h0);
        $display("overflow halt test done");
        fault <= 1'b1;
        run(32'h0000_1381, 400);
        check("frame events", 32'(n_err - e0 > 0), 32'h1);
        run(32'h0000_0381, 400);
        check("masked frame", 32'(n_err - e0), 32'h0);
        fault <= 1'b0;
        $display("frame fault test done");
        tally_and_finish();
    end
endmodule

// >>> verilog/sae_consts.svh
`ifndef SAE_CONSTS_SVH
`define SAE_CONSTS_SVH
// register map, one aligned word each
`define SAE_ADDR_W          8
`define SAE_OFF_CTRL2       8'h00
`define SAE_OFF_CTRL1       8'h04
`define SAE_OFF_STATUS      8'h08
`define SAE_OFF_TXDATA      8'h0c
`define SAE_OFF_RXDATA      8'h10
// control-two field positions
`define SAE_BIT_SGNEXT      15
`define SAE_BIT_FRMEN       12
`define SAE_BIT_ROVEN       11
`define SAE_BIT_TUREN       10
`define SAE_BIT_OVERFLOW_TOLERATE      9
`define SAE_BIT_UNDERRUN_TOLERATE      8
`define SAE_BIT_CODEC_PROTOCOL_EN       7
`define SAE_BIT_MONO        3
`define SAE_CTRL2_MASK      32'h0000_9f8b
`define SAE_CTRL2_RESET     32'h0000_0000
// control-one fields
`define SAE_BIT_ON          0
// status fields
`define SAE_BIT_ST_ROV      0
`define SAE_BIT_ST_TUR      1
`define SAE_BIT_ST_FRM      2
`define SAE_BIT_ST_HALT     3
`define SAE_BIT_ST_RXFULL   4
`define SAE_BIT_ST_TXFULL   5
// framing codes
`define SAE_FRM_I2S         2'b00
`define SAE_FRM_LJ          2'b01
`define SAE_FRM_RJ          2'b10
`define SAE_FRM_PCM         2'b11
`endif

// >>> verilog/sae_link.sv
`include "sae_consts.svh"
// link-side serialiser on the codec clock; 16-bit slots, word select from the frame counter
module sae_link
    import sae_pkg::*;
(
    input  wire logic        link_clk,
    input  wire logic        rst_b,
    input  wire logic        run,
    input  wire logic        audio,
    input  wire logic        mono,
    input  wire logic [1:0]  style,
    input  wire logic        tx_have,
    input  wire logic [15:0] tx_word,
    output logic             tx_take,
    output logic             ws,
    output logic             sdo,
    input  wire logic        sdi,
    output sae_word_t        rx_out,
    output logic             frame_err,
    input  wire logic        fs_in
);
    logic [4:0]  cnt_ff;
    logic [15:0] sh_ff;
    logic [15:0] rsh_ff;
    logic [15:0] left_ff;
    logic        fs_seen_ff;
    wire         slot_end = (cnt_ff[3:0] == 4'hf);
    // mono repeats the right-slot word in the next frame's left slot
    wire         rep = audio && mono && cnt_ff[4]; // [RL10] [RL13]
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff  <= 5'h00;
            sh_ff   <= 16'h0000;
            rsh_ff  <= 16'h0000;
            left_ff <= 16'h0000;
            tx_take <= 1'b0;
            rx_out  <= '0;
        end else begin
            tx_take <= 1'b0;
            rx_out.valid <= 1'b0;
            if (run) begin
                cnt_ff <= cnt_ff + 5'h01;
                rsh_ff <= {rsh_ff[14:0], sdi};
                if (slot_end) begin
                    rx_out.valid <= 1'b1;
                    rx_out.data  <= {rsh_ff[14:0], sdi};
                    if (rep) begin
                        sh_ff <= left_ff;
                    end else begin
                        // underrun sends zeros until data returns
                        sh_ff   <= tx_have ? tx_word : 16'h0000; // [RL7]
                        left_ff <= tx_have ? tx_word : 16'h0000;
                        tx_take <= tx_have;
                    end
                end else begin
                    sh_ff <= {sh_ff[14:0], 1'b0};
                end
            end else begin
                cnt_ff <= 5'h00;
            end
        end
    end
    // sync pulse polarity and timing per framing, only in audio mode
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            ws  <= 1'b0;
            sdo <= 1'b0;
        end else begin
            sdo <= sh_ff[15];
            if (!audio) begin
                ws <= 1'b0; // [RL13]
            end else begin
                case (style) // [RL11]
                    `SAE_FRM_I2S: ws <= cnt_ff[4] ^ slot_end;
                    `SAE_FRM_LJ:  ws <= ~cnt_ff[4];
                    `SAE_FRM_RJ:  ws <= ~cnt_ff[4];
                    `SAE_FRM_PCM: ws <= (cnt_ff == 5'h1f);
                    default:      ws <= 1'b0;
                endcase
            end
        end
    end
    // external sync arriving mid-frame is a frame fault
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_seen_ff <= 1'b0;
            frame_err  <= 1'b0;
        end else begin
            fs_seen_ff <= fs_in;
            frame_err  <= run && fs_in && !fs_seen_ff && (cnt_ff != 5'h00);
        end
    end
endmodule

// >>> verilog/sae_pkg.sv
package sae_pkg;
    typedef enum logic [1:0] {
        SAE_I2S,
        SAE_LJ,
        SAE_RJ,
        SAE_PCM
    } sae_framing_t;
    typedef struct packed {
        logic         rx_sign_extend;
        logic         frame_fault_event_en;
        logic         rx_overflow_event_en;
        logic         tx_underrun_event_en;
        logic         overflow_tolerate;
        logic         underrun_tolerate;
        logic         codec_protocol_en;
        logic         single_channel_format;
        sae_framing_t codec_framing_style;
    } sae_ctrl_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sae_word_t;
endpackage

// >>> verilog/sae_top.sv
// Operation
// RL1: set sign-extends receive words on read; clear returns them raw
// RL2: frame error raises an error event only while its enable is set
// RL3: receive overflow raises an error event only while its enable is set
// RL4: transmit underrun raises an error event only while its enable is set
// RL5: overflow tolerated keeps held receive data, new word dropped
// RL6: overflow not tolerated halts the port
// RL7: underrun tolerated sends zero words until transmit data returns
// RL8: underrun not tolerated halts the port
// RL9: codec enable switches the port into audio protocol operation
// RL10: mono sends each word on both left and right channels
// RL11: framing code 11 PCM, 10 right, 01 left, 00 I2S
// RL12: software changes codec fields only while module disabled
// RL13: mono and framing take effect only when codec enable is one
// RL14: upper sixteen and unused bits read as zero
// RL15: writes to unimplemented bits have no effect
`include "sae_consts.svh"
module sae_top
    import sae_pkg::*;
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_B,
    input  wire logic [`SAE_ADDR_W-1:0] ADDR,
    input  wire logic [31:0]            WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [31:0]            RDATA,
    input  wire logic                   LINK_CLK,
    output logic                        LINK_WS,
    output logic                        LINK_SDO,
    input  wire logic                   LINK_SDI,
    input  wire logic                   LINK_FS,
    output logic                        ERR_EVENT
);
    sae_ctrl_t   ctrl_ff;
    logic        on_ff;
    logic        rov_ff;
    logic        tur_ff;
    logic        frm_ff;
    logic        halt_ff;
    logic [15:0] tx_buf_ff;
    logic        tx_full_ff;
    logic [15:0] rx_buf_ff;
    logic        rx_full_ff;
    // core to link crossings
    logic [1:0]  run_s_ff;
    logic [3:0]  cfg_a_ff;
    logic [3:0]  cfg_b_ff;
    logic [1:0]  have_s_ff;
    logic [15:0] tx_word_l_ff;
    // link to core toggles
    logic        rx_tgl_l_ff;
    logic        take_tgl_l_ff;
    logic        frm_tgl_l_ff;
    logic        tur_tgl_l_ff;
    logic [15:0] rx_hold_l_ff;
    logic [2:0]  rx_tgl_s_ff;
    logic [2:0]  take_tgl_s_ff;
    logic [2:0]  frm_tgl_s_ff;
    logic [2:0]  tur_tgl_s_ff;
    logic [1:0]  sdi_s_ff;
    logic [1:0]  fs_s_ff;
    logic        tx_take;
    logic        l_ws;
    logic        l_sdo;
    logic        l_ferr;
    sae_word_t   l_rx;

    function automatic logic [31:0] ctrl_word(input sae_ctrl_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`SAE_BIT_SGNEXT] = c.rx_sign_extend;
        w[`SAE_BIT_FRMEN]  = c.frame_fault_event_en;
        w[`SAE_BIT_ROVEN]  = c.rx_overflow_event_en;
        w[`SAE_BIT_TUREN]  = c.tx_underrun_event_en;
        w[`SAE_BIT_OVERFLOW_TOLERATE] = c.overflow_tolerate;
        w[`SAE_BIT_UNDERRUN_TOLERATE] = c.underrun_tolerate;
        w[`SAE_BIT_CODEC_PROTOCOL_EN]  = c.codec_protocol_en;
        w[`SAE_BIT_MONO]   = c.single_channel_format;
        w[1:0]             = c.codec_framing_style;
        return w & `SAE_CTRL2_MASK; // [RL14]
    endfunction

    function automatic logic rise(input logic [2:0] s);
        return s[2] ^ s[1];
    endfunction

    wire wr_ctrl2 = WR && (ADDR == `SAE_OFF_CTRL2);
    wire wr_ctrl1 = WR && (ADDR == `SAE_OFF_CTRL1);
    wire wr_tx    = WR && (ADDR == `SAE_OFF_TXDATA);
    wire rd_rx    = RD && (ADDR == `SAE_OFF_RXDATA);
    wire wr_stat  = WR && (ADDR == `SAE_OFF_STATUS);
    wire rx_ev    = rise(rx_tgl_s_ff);
    wire take_ev  = rise(take_tgl_s_ff);
    wire frm_ev   = rise(frm_tgl_s_ff);
    wire tur_ev   = rise(tur_tgl_s_ff);
    wire rov_ev   = rx_ev && rx_full_ff && !rd_rx;

    // only implemented bits are stored; codec fields locked while on
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_ff <= '0;
        end else if (wr_ctrl2) begin
            ctrl_ff.rx_sign_extend       <= WDATA[`SAE_BIT_SGNEXT]; // [RL15]
            ctrl_ff.frame_fault_event_en <= WDATA[`SAE_BIT_FRMEN];
            ctrl_ff.rx_overflow_event_en <= WDATA[`SAE_BIT_ROVEN];
            ctrl_ff.tx_underrun_event_en <= WDATA[`SAE_BIT_TUREN];
            ctrl_ff.overflow_tolerate    <= WDATA[`SAE_BIT_OVERFLOW_TOLERATE];
            ctrl_ff.underrun_tolerate    <= WDATA[`SAE_BIT_UNDERRUN_TOLERATE];
            if (!on_ff) begin
                ctrl_ff.codec_protocol_en     <= WDATA[`SAE_BIT_CODEC_PROTOCOL_EN]; // [RL12]
                ctrl_ff.single_channel_format <= WDATA[`SAE_BIT_MONO];
                ctrl_ff.codec_framing_style   <= sae_framing_t'(WDATA[1:0]);
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            on_ff <= 1'b0;
        end else if (wr_ctrl1) begin
            on_ff <= WDATA[`SAE_BIT_ON];
        end
    end

    // sticky conditions: set wins over a write-one clear
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rov_ff  <= 1'b0;
            tur_ff  <= 1'b0;
            frm_ff  <= 1'b0;
            halt_ff <= 1'b0;
        end else begin
            rov_ff <= rov_ev || (rov_ff && !(wr_stat && WDATA[`SAE_BIT_ST_ROV]));
            tur_ff <= tur_ev || (tur_ff && !(wr_stat && WDATA[`SAE_BIT_ST_TUR]));
            frm_ff <= frm_ev || (frm_ff && !(wr_stat && WDATA[`SAE_BIT_ST_FRM]));
            if ((rov_ev && !ctrl_ff.overflow_tolerate) ||
                (tur_ev && !ctrl_ff.underrun_tolerate)) begin
                halt_ff <= 1'b1; // [RL6] [RL8]
            end else if (!on_ff) begin
                halt_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ERR_EVENT <= 1'b0;
        end else begin
            ERR_EVENT <= (frm_ev && ctrl_ff.frame_fault_event_en) || // [RL2]
                         (rov_ev && ctrl_ff.rx_overflow_event_en) || // [RL3]
                         (tur_ev && ctrl_ff.tx_underrun_event_en);   // [RL4]
        end
    end

    // a full buffer keeps its word; the overflowing one is discarded
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_buf_ff  <= 16'h0000;
            rx_full_ff <= 1'b0;
        end else begin
            if (rx_ev && (!rx_full_ff || rd_rx)) begin
                // link hold word is stable for a whole slot after its toggle
                rx_buf_ff  <= rx_hold_l_ff; // [RL5]
                rx_full_ff <= 1'b1;
            end else if (rd_rx) begin
                rx_full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_buf_ff  <= 16'h0000;
            tx_full_ff <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_buf_ff  <= WDATA[15:0];
                tx_full_ff <= 1'b1;
            end else if (take_ev) begin
                tx_full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `SAE_OFF_CTRL2:  RDATA <= ctrl_word(ctrl_ff);
                `SAE_OFF_CTRL1:  RDATA <= {31'h0, on_ff};
                `SAE_OFF_STATUS: RDATA <= {26'h0, tx_full_ff, rx_full_ff,
                                           halt_ff, frm_ff, tur_ff, rov_ff};
                `SAE_OFF_TXDATA: RDATA <= {16'h0000, tx_buf_ff};
                `SAE_OFF_RXDATA: RDATA <= ctrl_ff.rx_sign_extend ?         // [RL1]
                                          {{16{rx_buf_ff[15]}}, rx_buf_ff} :
                                          {16'h0000, rx_buf_ff};
                default:         RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

    // link domain: levels through two flops, events as toggles
    always_ff @(posedge LINK_CLK or negedge RST_B) begin
        if (!RST_B) begin
            run_s_ff     <= 2'b00;
            have_s_ff    <= 2'b00;
            sdi_s_ff     <= 2'b00;
            fs_s_ff      <= 2'b00;
            tx_word_l_ff <= 16'h0000;
            cfg_a_ff     <= 4'h0;
            cfg_b_ff     <= 4'h0;
        end else begin
            run_s_ff  <= {run_s_ff[0], on_ff && !halt_ff};
            // codec enable, mono and framing: the low bits of the packed control
            cfg_a_ff  <= ctrl_ff[3:0];
            cfg_b_ff  <= cfg_a_ff;
            have_s_ff <= {have_s_ff[0], tx_full_ff};
            sdi_s_ff  <= {sdi_s_ff[0], LINK_SDI};
            fs_s_ff   <= {fs_s_ff[0], LINK_FS};
            // buffer word is stable while its full level is seen set
            if (have_s_ff[1]) begin
                tx_word_l_ff <= tx_buf_ff;
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_tgl_l_ff   <= 1'b0;
            take_tgl_l_ff <= 1'b0;
            frm_tgl_l_ff  <= 1'b0;
            tur_tgl_l_ff  <= 1'b0;
            rx_hold_l_ff  <= 16'h0000;
        end else begin
            if (l_rx.valid) begin
                rx_tgl_l_ff  <= ~rx_tgl_l_ff;
                rx_hold_l_ff <= l_rx.data;
            end
            if (tx_take) begin
                take_tgl_l_ff <= ~take_tgl_l_ff;
            end
            if (l_ferr) begin
                frm_tgl_l_ff <= ~frm_tgl_l_ff;
            end
            if (run_s_ff[1] && !have_s_ff[1] && !tx_take && l_rx.valid) begin
                tur_tgl_l_ff <= ~tur_tgl_l_ff;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_tgl_s_ff   <= 3'b000;
            take_tgl_s_ff <= 3'b000;
            frm_tgl_s_ff  <= 3'b000;
            tur_tgl_s_ff  <= 3'b000;
        end else begin
            rx_tgl_s_ff   <= {rx_tgl_s_ff[1:0], rx_tgl_l_ff};
            take_tgl_s_ff <= {take_tgl_s_ff[1:0], take_tgl_l_ff};
            frm_tgl_s_ff  <= {frm_tgl_s_ff[1:0], frm_tgl_l_ff};
            tur_tgl_s_ff  <= {tur_tgl_s_ff[1:0], tur_tgl_l_ff};
        end
    end

    sae_link u_link (
        .link_clk  (LINK_CLK),
        .rst_b     (RST_B),
        .run       (run_s_ff[1]),
        .audio     (cfg_b_ff[3]), // [RL9]
        .mono      (cfg_b_ff[2]),
        .style     (cfg_b_ff[1:0]),
        .tx_have   (have_s_ff[1]),
        .tx_word   (tx_word_l_ff),
        .tx_take   (tx_take),
        .ws        (l_ws),
        .sdo       (l_sdo),
        .sdi       (sdi_s_ff[1]),
        .rx_out    (l_rx),
        .frame_err (l_ferr),
        .fs_in     (fs_s_ff[1])
    );

    always_ff @(posedge LINK_CLK or negedge RST_B) begin
        if (!RST_B) begin
            LINK_WS  <= 1'b0;
            LINK_SDO <= 1'b0;
        end else begin
            LINK_WS  <= l_ws;
            LINK_SDO <= l_sdo;
        end
    end
endmodule
